// [rtl/vet_top.v]
// Top control of the composite / S-video encoder: control bus slave,
// reset handling, pixel port, text handshake, subcarrier and output stage.
// Assumes one clock (clk) and open-drain resolution of the data pin outside.
// Summary of operation
// - Slave address 88h, or 8ch with select high
// - Digital pins stay inputs during and after reset
// - Bus receiver idles until a START condition
// - Reset aborts any running bus transfer
// - Reset loads 3a with 03h, 61 with 06h
// - Reset clears 6bh, 6eh and text flag
// - All other control registers ignore reset
// - Request output marks when text bits needed
// - 8-bit multiplexed input, code decode in slave
// - Twice oversampled 10-bit Y, C, composite
// - 50 Hz: wide-screen data into line 23
// - Caption bytes encoded into line 21
// - Realtime input supplies subcarrier, id, phase
// - NTSC and PAL, interlaced or progressive
// - All timing derived from the one clock
// - Subcarrier, quadrature modulation, sync insertion
// - The clock input is the master clock
// - Auto-increment subaddress, only status readable
`include "vet_consts.vh"
`default_nettype none
module vet_top (
  input  wire       clk,
  input  wire       resetn,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_o,
  output reg        sda_oe,
  input  wire       address_select_pin,
  input  wire [7:0] pixel_input_bits,
  input  wire       realtime_control_in,
  input  wire       text_bitstream_in,
  output reg        text_request_out,
  input  wire       sample_ready,
  output reg        sample_valid,
  output reg  [9:0] y_out,
  output reg  [9:0] c_out,
  output reg  [9:0] cvbs_out
);
  localparam I_IDLE = 4'd0, I_ADDR = 4'd1, I_AACK = 4'd2, I_SUB  = 4'd3;
  localparam I_SACK = 4'd4, I_WDAT = 4'd5, I_DACK = 4'd6, I_RDAT = 4'd7;
  localparam I_RACK = 4'd8;

  // Reset release synchroniser; assertion stays asynchronous
  reg rst_m_q, rst_n;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_m_q <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n   <= rst_m_q;
    end
  end

  // Two-stage synchronisers for every pin input except sample_ready
  wire [12:0] pin_raw = {scl_in, sda_in, address_select_pin,
                         realtime_control_in, text_bitstream_in,
                         pixel_input_bits};
  reg  [12:0] pin_m_q, pin_s_q;
  reg         scl_d_q, sda_d_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_m_q <= 13'h1800;
      pin_s_q <= 13'h1800;
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
      scl_d_q <= pin_s_q[12];
      sda_d_q <= pin_s_q[11];
    end
  end
  wire       scl = pin_s_q[12];
  wire       sda = pin_s_q[11];
  wire       rtc = pin_s_q[9];
  wire       txt = pin_s_q[8];
  wire [7:0] pix = pin_s_q[7:0];
  wire scl_rise = scl & ~scl_d_q;
  wire scl_fall = ~scl & scl_d_q;
  wire start_c  = scl & scl_d_q & sda_d_q & ~sda;
  wire stop_c   = scl & scl_d_q & ~sda_d_q & sda;
  wire [7:0] my_addr = pin_s_q[10] ? `VET_ADDR_HIGH : `VET_ADDR_LOW;

  // Bus slave state machine; reset drops any transfer
  reg [3:0] ist_q;
  reg [3:0] bcnt_q;
  reg [7:0] sh_q, tx_q, sub_q, wdat_q;
  reg       rw_q, wr_q;
  wire [7:0] status;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ist_q  <= I_IDLE;
      bcnt_q <= 4'h0;
      sh_q   <= 8'h00;
      tx_q   <= 8'h00;
      sub_q  <= 8'h00;
      wdat_q <= 8'h00;
      rw_q   <= 1'b0;
      wr_q   <= 1'b0;
      sda_oe <= 1'b0;
      sda_o  <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      if (start_c) begin
        ist_q  <= I_ADDR;
        bcnt_q <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        ist_q  <= I_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (ist_q)
          I_IDLE: ist_q <= I_IDLE;
          I_ADDR, I_SUB, I_WDAT: begin
            if (scl_rise) begin
              sh_q   <= {sh_q[6:0], sda};
              bcnt_q <= bcnt_q + 4'h1;
            end else if (scl_fall && bcnt_q == 4'h8) begin
              bcnt_q <= 4'h0;
              if (ist_q == I_ADDR) begin
                if ({sh_q[7:1], 1'b0} == my_addr) begin
                  sda_oe <= 1'b1;
                  rw_q   <= sh_q[0];
                  ist_q  <= I_AACK;
                end else begin
                  ist_q <= I_IDLE;
                end
              end else if (ist_q == I_SUB) begin
                sub_q  <= sh_q;
                sda_oe <= 1'b1;
                ist_q  <= I_SACK;
              end else begin
                wr_q   <= 1'b1;
                wdat_q <= sh_q;
                sda_oe <= 1'b1;
                ist_q  <= I_DACK;
              end
            end
          end
          I_AACK: begin
            if (scl_fall) begin
              if (rw_q) begin
                tx_q   <= status;
                sda_oe <= ~status[7];
                ist_q  <= I_RDAT;
              end else begin
                sda_oe <= 1'b0;
                ist_q  <= I_SUB;
              end
            end
          end
          I_SACK, I_DACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              ist_q  <= I_WDAT;
              if (ist_q == I_DACK)
                sub_q <= sub_q + 8'h01;
            end
          end
          I_RDAT: begin
            if (scl_fall) begin
              if (bcnt_q == 4'h7) begin
                sda_oe <= 1'b0;
                bcnt_q <= 4'h0;
                ist_q  <= I_RACK;
              end else begin
                tx_q   <= {tx_q[6:0], 1'b0};
                sda_oe <= ~tx_q[6];
                bcnt_q <= bcnt_q + 4'h1;
              end
            end
          end
          I_RACK: begin
            // Master not-acknowledge ends the read
            if (scl_rise && sda) begin
              ist_q <= I_IDLE;
            end else if (scl_fall) begin
              tx_q   <= status;
              sda_oe <= ~status[7];
              ist_q  <= I_RDAT;
            end
          end
          default: ist_q <= I_IDLE;
        endcase
      end
    end
  end

  // General control store; no reset so values survive a reset pulse
  reg [7:0] mem [0:255];
  always @(posedge clk) begin
    if (wr_q)
      mem[sub_q] <= wdat_q;
  end

  // Registers with defined reset values
  reg [7:0] ra_q, rb_q, rc_q, rd_q;
  reg       txf_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ra_q  <= `VET_RST_A;
      rb_q  <= `VET_RST_B;
      rc_q  <= `VET_RST_C;
      rd_q  <= `VET_RST_D;
      txf_q <= `VET_RST_TXF;
    end else if (wr_q) begin
      case (sub_q)
        `VET_REG_A:   ra_q  <= wdat_q;
        `VET_REG_B:   rb_q  <= wdat_q;
        `VET_REG_C:   rc_q  <= wdat_q;
        `VET_REG_D:   rd_q  <= wdat_q;
        `VET_REG_TXF: txf_q <= wdat_q[`VET_TXF_BIT];
        default:      txf_q <= txf_q;
      endcase
    end
  end
  wire dec_en = ra_q[`VET_A_SAVDEC];
  wire pal    = ra_q[`VET_A_PAL];
  wire [31:0] inc_reg = {mem[`VET_REG_INC3], mem[`VET_REG_INC2],
                         mem[`VET_REG_INC1], mem[`VET_REG_INC0]};

  // Line timing, free running or locked to timing reference codes
  reg [10:0] hcnt_q;
  reg [9:0]  lcnt_q;
  reg        field_q, act_q;
  reg [7:0]  p1_q, p2_q, p3_q;
  wire trs = (p3_q == 8'hff) && (p2_q == 8'h00) && (p1_q == 8'h00);
  wire [9:0] nlines = (pal ? `VET_LINES_PAL : `VET_LINES_NTSC)
                      - {9'h000, ra_q[`VET_A_PROG]};
  wire code_eav = dec_en && trs && pix[4];
  wire code_sav = dec_en && trs && !pix[4];
  wire new_line = dec_en ? code_eav : (hcnt_q == `VET_LINE_CYC - 11'd1);
  wire wrap     = dec_en ? (field_q & ~pix[6]) : (lcnt_q == nlines);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hcnt_q  <= 11'h000;
      lcnt_q  <= 10'h001;
      field_q <= 1'b0;
      act_q   <= 1'b0;
      p1_q    <= 8'h00;
      p2_q    <= 8'h00;
      p3_q    <= 8'h00;
    end else begin
      p1_q <= pix;
      p2_q <= p1_q;
      p3_q <= p2_q;
      hcnt_q <= new_line ? 11'h000 : hcnt_q + 11'h001;
      if (new_line) begin
        lcnt_q  <= wrap ? 10'h001 : lcnt_q + 10'h001;
        field_q <= dec_en ? pix[6] : (wrap ? ~field_q : field_q);
      end
      if (dec_en)
        act_q <= code_sav ? 1'b1 : (code_eav ? 1'b0 : act_q);
      else
        act_q <= (hcnt_q >= `VET_ACT_START);
    end
  end

  // Demultiplex Cb Y Cr Y into words for the two-entry buffer
  reg [1:0]  ph_q;
  reg [23:0] part_q;
  reg [31:0] fmem [0:1];
  reg        wp_q, rp_q;
  reg [1:0]  fcnt_q;
  reg        ovf_q;
  wire push    = act_q && !code_sav && (ph_q == 2'd3);
  wire f_ready = (fcnt_q != 2'd2);
  wire f_valid = (fcnt_q != 2'd0);
  reg  [1:0] os_q;
  wire pop     = sample_ready && (os_q == 2'd3) && f_valid;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q   <= 2'd0;
      part_q <= 24'h000000;
      wp_q   <= 1'b0;
      rp_q   <= 1'b0;
      fcnt_q <= 2'd0;
      ovf_q  <= 1'b0;
    end else begin
      ph_q <= (code_sav || !act_q) ? 2'd0 : ph_q + 2'd1;
      case (ph_q)
        2'd0:    part_q[23:16] <= pix;
        2'd1:    part_q[15:8]  <= pix;
        2'd2:    part_q[7:0]   <= pix;
        default: part_q        <= part_q;
      endcase
      // Pixel pins cannot stall, so a full buffer drops and flags
      if (push && !f_ready)
        ovf_q <= 1'b1;
      if (push && f_ready)
        wp_q <= ~wp_q;
      if (pop)
        rp_q <= ~rp_q;
      fcnt_q <= fcnt_q + {1'b0, push && f_ready} - {1'b0, pop};
    end
  end
  always @(posedge clk) begin
    if (push && f_ready)
      fmem[wp_q] <= {part_q, pix};
  end

  // Subcarrier oscillator and realtime control receiver
  reg [31:0] phase_q, rt_inc_q;
  reg [23:0] rt_sh_q;
  reg [4:0]  rt_cnt_q;
  reg        rt_ok_q, pal_id_q;
  wire rt_done = (rt_cnt_q == `VET_RTC_BITS);
  wire rt_use  = rb_q[`VET_B_RTC] && rt_ok_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q  <= 32'h00000000;
      rt_inc_q <= 32'h00000000;
      rt_sh_q  <= 24'h000000;
      rt_cnt_q <= 5'd0;
      rt_ok_q  <= 1'b0;
      pal_id_q <= 1'b0;
    end else begin
      if (rt_cnt_q == 5'd0) begin
        if (rtc && rb_q[`VET_B_RTC])
          rt_cnt_q <= 5'd1;
      end else if (rt_done) begin
        rt_cnt_q <= 5'd0;
        rt_inc_q <= {rt_sh_q[23:2], 10'h000};
        pal_id_q <= rt_sh_q[1];
        rt_ok_q  <= 1'b1;
      end else begin
        rt_sh_q  <= {rt_sh_q[22:0], rtc};
        rt_cnt_q <= rt_cnt_q + 5'd1;
      end
      if (rt_done && rt_sh_q[0])
        phase_q <= 32'h00000000;
      else
        phase_q <= phase_q + (rt_use ? rt_inc_q : inc_reg);
    end
  end

  // Caption and wide-screen bits, text request and sampling
  wire cc_line  = (lcnt_q == `VET_LINE_CC);
  wire wss_line = pal && rb_q[`VET_B_WSS]
                  && (lcnt_q == `VET_LINE_WSS);
  reg [15:0] dsh_q;
  reg [6:0]  dcyc_q;
  reg [4:0]  didx_q;
  reg        dwin_q, twin_q, tbit_q;
  reg [2:0]  tcyc_q;
  reg [8:0]  tnum_q;
  reg [7:0]  tdly_q;
  reg        tpend_q;
  wire t_line = txf_q && (lcnt_q == {2'b00, rc_q});
  wire [8:0] tbits = pal ? `VET_TXT_BITS_P : `VET_TXT_BITS_N;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dsh_q <= 16'h0000;
      dcyc_q <= 7'd0;
      didx_q <= 5'd0;
      dwin_q <= 1'b0;
      twin_q <= 1'b0;
      tbit_q <= 1'b0;
      tcyc_q <= 3'd0;
      tnum_q <= 9'd0;
      tdly_q <= 8'h00;
      tpend_q <= 1'b0;
      text_request_out <= 1'b0;
    end else begin
      if (hcnt_q == `VET_DATA_START && (cc_line || wss_line)) begin
        dsh_q  <= cc_line ? {mem[`VET_REG_CC1], mem[`VET_REG_CC0]}
                          : {mem[`VET_REG_WSS1], mem[`VET_REG_WSS0]};
        dwin_q <= 1'b1;
        dcyc_q <= 7'd0;
        didx_q <= 5'd0;
      end else if (dwin_q) begin
        if (dcyc_q == `VET_CC_BIT_CYC - 7'd1) begin
          dcyc_q <= 7'd0;
          dsh_q  <= {1'b0, dsh_q[15:1]};
          didx_q <= didx_q + 5'd1;
          if (didx_q == `VET_DATA_BITS - 5'd1)
            dwin_q <= 1'b0;
        end else begin
          dcyc_q <= dcyc_q + 7'd1;
        end
      end
      // One request pulse per text bit inside the window
      if (hcnt_q == `VET_TXT_START && t_line) begin
        twin_q <= 1'b1;
        tcyc_q <= 3'd0;
        tnum_q <= 9'd0;
      end else if (twin_q) begin
        tcyc_q <= tcyc_q + 3'd1;
        if (tcyc_q == `VET_TXT_BIT_CYC - 3'd1) begin
          tcyc_q <= 3'd0;
          tnum_q <= tnum_q + 9'd1;
          if (tnum_q == tbits - 9'd1)
            twin_q <= 1'b0;
        end
      end
      text_request_out <= twin_q && (tcyc_q == 3'd0);
      // Delay longer than a bit period restarts on the next request
      if (text_request_out) begin
        tdly_q  <= rd_q;
        tpend_q <= 1'b1;
      end else if (tpend_q) begin
        if (tdly_q == 8'h00) begin
          tbit_q  <= txt;
          tpend_q <= 1'b0;
        end else begin
          tdly_q <= tdly_q - 8'h01;
        end
      end
    end
  end

  // Output stage: four samples per word, sync and data overlays
  reg [31:0] cur_q;
  wire [7:0] cb = cur_q[31:24];
  wire [7:0] y0 = cur_q[23:16];
  wire [7:0] cr = cur_q[15:8];
  wire [7:0] y1 = cur_q[7:0];
  wire [8:0] ysum = {1'b0, y0} + {1'b0, y1};
  wire [7:0] ysel = (os_q == 2'd0) ? y0 :
                    (os_q == 2'd1) ? ysum[8:1] : y1;
  wire [7:0] csel = phase_q[30] ? cr : cb;
  wire [9:0] cmod = phase_q[31] ? (10'h300 - {1'b0, csel, 1'b0})
                                : ({1'b0, csel, 1'b0} + 10'h100);
  reg  [9:0] ynx, cnx;
  always @* begin
    ynx = {ysel, 2'b00};
    cnx = cmod;
    if (hcnt_q < `VET_HSYNC_CYC) begin
      ynx = `VET_LVL_SYNC;
      cnx = `VET_LVL_CMID;
    end else if (dwin_q) begin
      ynx = dsh_q[0] ? `VET_LVL_DHIGH : `VET_LVL_BLACK;
      cnx = `VET_LVL_CMID;
    end else if (twin_q) begin
      ynx = tbit_q ? `VET_LVL_WHITE : `VET_LVL_BLACK;
      cnx = `VET_LVL_CMID;
    end
  end
  // Saturate at full scale only; a dip below zero wraps unclipped
  wire [10:0] vsum = {1'b0, ynx} + {1'b0, cnx};
  wire [9:0]  vdif = vsum[9:0] - `VET_LVL_CMID;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      os_q <= 2'd0;
      cur_q <= 32'h80108010;
      sample_valid <= 1'b0;
      y_out <= 10'h000;
      c_out <= 10'h000;
      cvbs_out <= 10'h000;
    end else if (sample_ready) begin
      os_q <= os_q + 2'd1;
      if (os_q == 2'd3)
        cur_q <= f_valid ? fmem[rp_q] : 32'h80108010;
      sample_valid <= 1'b1;
      y_out <= ynx;
      c_out <= cnx;
      cvbs_out <= (vsum[10:9] == 2'b11) ? 10'h3ff : vdif;
    end
  end

  assign status = {2'b00, ovf_q, pal_id_q, field_q, twin_q, dwin_q,
                   act_q};
endmodule // vet_top
`default_nettype wire

// [rtl/vet_consts.vh]
// Constants of the video encoder top control: bus addresses, register
// offsets, reset values, field positions, timing counts and levels.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef VET_CONSTS_VH
`define VET_CONSTS_VH
// Bus addresses, address select pin low / high
`define VET_ADDR_LOW    8'h88
`define VET_ADDR_HIGH   8'h8c
// Register offsets
`define VET_REG_A       8'h3a
`define VET_REG_B       8'h61
`define VET_REG_C       8'h6b
`define VET_REG_D       8'h6e
`define VET_REG_TXF     8'h6f
`define VET_REG_CC0     8'h54
`define VET_REG_CC1     8'h55
`define VET_REG_WSS0    8'h56
`define VET_REG_WSS1    8'h57
`define VET_REG_INC0    8'h5c
`define VET_REG_INC1    8'h5d
`define VET_REG_INC2    8'h5e
`define VET_REG_INC3    8'h5f
// Reset values
`define VET_RST_A       8'h03
`define VET_RST_B       8'h06
`define VET_RST_C       8'h00
`define VET_RST_D       8'h00
`define VET_RST_TXF     1'b0
// Field positions
`define VET_A_SAVDEC    0
`define VET_A_PAL       1
`define VET_A_PROG      2
`define VET_B_WSS       1
`define VET_B_RTC       2
`define VET_TXF_BIT     0
// Timing counts in clock cycles, bits and lines
`define VET_LINE_CYC    11'd1728
`define VET_HSYNC_CYC   11'd128
`define VET_ACT_START   11'd288
`define VET_DATA_START  11'd300
`define VET_TXT_START   11'd200
`define VET_CC_BIT_CYC  7'd54
`define VET_DATA_BITS   5'd16
`define VET_TXT_BIT_CYC 3'd4
`define VET_TXT_BITS_P  9'd360
`define VET_TXT_BITS_N  9'd296
`define VET_LINES_PAL   10'd625
`define VET_LINES_NTSC  10'd525
`define VET_LINE_WSS    10'd23
`define VET_LINE_CC     10'd21
`define VET_RTC_BITS    5'd25
// Output levels, 10 bit
`define VET_LVL_SYNC    10'h010
`define VET_LVL_BLACK   10'h100
`define VET_LVL_WHITE   10'h3ac
`define VET_LVL_DHIGH   10'h200
`define VET_LVL_CMID    10'h200
`endif

// [test/vet_top_asserts.sv]
// Concurrent checks on the encoder top control, from its ports only.
// Assumes a bind onto vet_top placed in the bench's top file.
`default_nettype none
module vet_chk (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       scl_in,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       text_request_out,
  input wire logic       sample_ready,
  input wire logic       sample_valid,
  input wire logic [9:0] y_out,
  input wire logic [9:0] c_out,
  input wire logic [9:0] cvbs_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] cv_sum;
  logic [9:0]  cv_exp;
  // Composite sum wraps below zero, clips only at the top
  assign cv_sum = {2'b00, y_out} + {2'b00, c_out} - 12'h200;
  assign cv_exp = (cv_sum[11:10] == 2'b01) ? 10'h3ff : cv_sum[9:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Reset itself is the cause here, so it cannot disable the check
  a_reset_pins_in: assert property (
    disable iff (1'b0) !resetn |-> !sda_oe && !text_request_out)
    else $error("pin driven while reset held");
  a_release_quiet: assert property (
    $rose(resetn) |-> !sda_oe [*4])
    else $error("data pin driven right after reset");
  a_open_drain: assert property (
    sda_oe |-> sda_o == 1'b0)
    else $error("data pin driven high");
  a_ack_scl_low: assert property (
    $rose(sda_oe) |-> !scl_in)
    else $error("data pin taken while bus clock high");
  a_text_gap: assert property (
    text_request_out |=> !text_request_out [*3])
    else $error("text request pulses too close");
  // Synchroniser delays the first useful edge after release
  a_valid_ready: assert property (
    $past(resetn) && $past(resetn, 2) && $past(resetn, 3) &&
    sample_ready |=> sample_valid)
    else $error("sample valid missing after ready");
  a_outs_hold: assert property (
    sample_valid && !sample_ready |=>
    $stable(y_out) && $stable(c_out) && $stable(cvbs_out))
    else $error("samples changed during stall");
  a_cvbs_sum: assert property (
    sample_valid |-> cvbs_out == cv_exp)
    else $error("composite not sum of luma and chroma");
  c_ack: cover property (sda_oe);
  c_text: cover property (text_request_out);
  c_stall: cover property (sample_valid && !sample_ready);
endmodule // vet_chk
`default_nettype wire

// [test/vet_src_model.sv]
// Model of the upstream decoder: pixel byte stream and text source.
// Assumes the bench clock and reset; realtime link left idle.
`default_nettype none
module vet_src_model (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       text_request_out,
  output var  logic [7:0] pixel_input_bits,
  output var  logic       text_bitstream_in,
  output var  logic       realtime_control_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] cnt_q;
  logic       req_q;
  // Bytes kept below ff so no stray timing code is formed
  always @(negedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 7'h00;
      req_q <= 1'b0;
      text_bitstream_in <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 7'h01;
      req_q <= text_request_out;
      // New bit after each request, held until the next one
      if (text_request_out && !req_q)
        text_bitstream_in <= ~text_bitstream_in;
    end
  end
  assign pixel_input_bits = 8'h10 + {1'b0, cnt_q};
  assign realtime_control_in = 1'b0; // No decoder frames sent
endmodule // vet_src_model
`default_nettype wire

// [test/vet_top_test.sv]
// Self-checking bench of the encoder top control over its serial bus.
// Assumes vet_top, vet_chk and vet_src_model compiled beforehand.
`include "vet_consts.vh"
`default_nettype none
module vet_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk;
  logic       resetn;
  logic       scl_in;
  logic       m_sda;
  logic       sel;
  logic       sample_ready;
  wire  logic sda_w;
  wire  logic sda_o;
  wire  logic sda_oe;
  wire  logic treq;
  wire  logic tbit;
  wire  logic rtc;
  wire  logic svalid;
  wire  logic [7:0] pix;
  wire  logic [9:0] y_out;
  wire  logic [9:0] c_out;
  wire  logic [9:0] cvbs_out;
  int         n_mismatch = 0;
  int         checks = 0;
  int         cyc = 0;
  // Open-drain data line with pull-up
  assign sda_w = sda_oe ? 1'b0 : m_sda;
  vet_top i_vet_top (.clk(clk), .resetn(resetn), .scl_in(scl_in),
    .sda_in(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .address_select_pin(sel), .pixel_input_bits(pix),
    .realtime_control_in(rtc), .text_bitstream_in(tbit),
    .text_request_out(treq), .sample_ready(sample_ready),
    .sample_valid(svalid), .y_out(y_out), .c_out(c_out),
    .cvbs_out(cvbs_out));
  vet_src_model i_vet_src_model (.clk(clk), .resetn(resetn),
    .text_request_out(treq), .pixel_input_bits(pix),
    .text_bitstream_in(tbit), .realtime_control_in(rtc));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      conclude;
    end
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp_bit(input string w, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %b seen %b", w, e, g);
    end
  endtask
  task automatic cmp_byte(input string w, input logic [7:0] e,
                          input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask
  task automatic cmp_count(input string w, input int e, input int g);
    checks++;
    if (g != e) begin
      n_mismatch++;
      $display("unexpected %s: expected %0d seen %0d", w, e, g);
    end
  endtask
  // Bus phases last 8 cycles, well over the pin synchroniser
  task automatic hold;
    repeat (8) @(negedge clk);
  endtask
  task automatic i2c_start;
    m_sda = 1'b1;
    hold;
    scl_in = 1'b1;
    hold;
    m_sda = 1'b0;
    hold;
    scl_in = 1'b0;
    hold;
  endtask
  task automatic i2c_stop;
    m_sda = 1'b0;
    hold;
    scl_in = 1'b1;
    hold;
    m_sda = 1'b1;
    hold;
  endtask
  task automatic send_bits(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      m_sda = b[i];
      hold;
      scl_in = 1'b1;
      hold;
      scl_in = 1'b0;
      hold;
    end
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    send_bits(b);
    m_sda = 1'b1;
    hold;
    scl_in = 1'b1;
    hold;
    ack = !sda_w;
    scl_in = 1'b0;
    hold;
  endtask
  // One byte in, then a not-acknowledge ends the read
  task automatic read_byte(output logic [7:0] b);
    m_sda = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      hold;
      scl_in = 1'b1;
      hold;
      b[i] = sda_w;
      scl_in = 1'b0;
    end
    hold;
    scl_in = 1'b1;
    hold;
    scl_in = 1'b0;
    hold;
  endtask
  task automatic wr(input logic [7:0] sub, input logic [7:0] d[$]);
    logic a;
    i2c_start;
    send_byte(`VET_ADDR_LOW, a);
    cmp_bit("write address ack", 1'b1, a);
    send_byte(sub, a);
    cmp_bit("subaddress ack", 1'b1, a);
    foreach (d[i]) begin
      send_byte(d[i], a);
      cmp_bit("data ack", 1'b1, a);
    end
    i2c_stop;
  endtask
  task automatic rd_status(output logic [7:0] b);
    logic a;
    i2c_start;
    send_byte(`VET_ADDR_LOW | 8'h01, a);
    cmp_bit("read address ack", 1'b1, a);
    read_byte(b);
    i2c_stop;
  endtask
  task automatic count_req(input int n_cyc, output int n);
    n = 0;
    repeat (n_cyc) begin
      @(negedge clk);
      if (treq === 1'b1)
        n++;
    end
  endtask
  // Main sequence
  initial begin
    logic       a;
    logic [7:0] b;
    int         n;
    resetn = 1'b1;
    scl_in = 1'b1;
    m_sda = 1'b1;
    sel = 1'b0;
    sample_ready = 1'b0;
    // Clean falling reset edge ahead of the first clock edge
    #1 resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    hold;
    // Line bytes and increment first; accumulator must not start unknown
    wr(`VET_REG_CC0, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h00,
                       8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08});
    // Reset again: stored bytes survive, accumulator restarts
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    sample_ready = 1'b1;
    hold;
    // Address without a START must be ignored
    send_byte(`VET_ADDR_LOW, a);
    cmp_bit("ack without start", 1'b0, a);
    i2c_stop;
    // Both addresses against both select levels
    for (int s = 0; s < 2; s++) begin
      sel = s[0];
      for (int k = 0; k < 2; k++) begin
        i2c_start;
        send_byte(k ? `VET_ADDR_HIGH : `VET_ADDR_LOW, a);
        cmp_bit("address ack", s == k, a);
        i2c_stop;
      end
    end
    sel = 1'b0;
    rd_status(b);
    cmp_byte("status top bits", 8'h00, b & 8'he0);
    // Free-running 50 Hz timing, so active video fills the buffer
    wr(`VET_REG_A, '{8'h02});
    // Stall longer than the blank part of a line to overrun the buffer
    sample_ready = 1'b0;
    repeat (400) @(negedge clk);
    sample_ready = 1'b1;
    rd_status(b);
    cmp_byte("status overflow", 8'h20, b & 8'he0);
    // Text window on line 10, 50 Hz, free-running timing
    wr(`VET_REG_A, '{8'h02});
    wr(`VET_REG_C, '{8'h0a, 8'h00, 8'h00, 8'h02, 8'h01});
    count_req(22000, n);
    cmp_count("text requests", 360, n);
    // Reset while the device acknowledges a byte
    i2c_start;
    send_byte(`VET_ADDR_LOW, a);
    send_bits(`VET_REG_TXF);
    cmp_bit("ack before abort", 1'b1, sda_oe);
    resetn = 1'b0;
    scl_in = 1'b1;
    m_sda = 1'b1;
    @(negedge clk);
    cmp_bit("data pin in reset", 1'b0, sda_oe);
    @(negedge clk);
    resetn = 1'b1;
    hold;
    rd_status(b);
    cmp_byte("status after reset", 8'h00, b & 8'he0);
    // Flag must stay cleared: same line and delay, no requests
    wr(`VET_REG_A, '{8'h02});
    wr(`VET_REG_C, '{8'h0a, 8'h00, 8'h00, 8'h02});
    count_req(22000, n);
    cmp_count("requests with flag cleared", 0, n);
    conclude;
  end
endmodule // vet_top_test
bind vet_top vet_chk i_vet_chk (.clk(clk), .resetn(resetn),
  .scl_in(scl_in), .sda_o(sda_o), .sda_oe(sda_oe),
  .text_request_out(text_request_out), .sample_ready(sample_ready),
  .sample_valid(sample_valid), .y_out(y_out), .c_out(c_out),
  .cvbs_out(cvbs_out));
`default_nettype wire
